/* rtl/pcm_voice_port.sv */
// PCM voice port: codec link, codec master clock and Avalon-MM registers
`timescale 1ns/1ns
`default_nettype none
module pcm_voice_port
  import voice_port_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic voice_frame_sync_out,
  output logic voice_frame_sync_oe_out,
  input wire logic voice_frame_sync_in,
  output logic voice_bclk_out,
  output logic voice_bclk_oe_out,
  input wire logic voice_bclk_in,
  output logic voice_dout_out,
  output logic voice_dout_oe_out,
  input wire logic voice_din_in,
  output logic codec_mclk_out
);
  import voice_port_pkg::*;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;

  function automatic logic [11:0] half_period(input logic [1:0] rate, input logic long_mode);
    if (long_mode) begin
      half_period = 12'(HALF_LONG);
    end else begin
      unique case (rate)
        RATE_256K: half_period = 12'(HALF_256K);
        RATE_512K: half_period = 12'(HALF_512K);
        RATE_1024K: half_period = 12'(HALF_1024K);
        default: half_period = 12'(HALF_2048K);
      endcase
    end
  endfunction

  logic [15:0] ctrl_ff;
  bus_state_t bus_ff;
  logic [31:0] rdata_ff;
  logic wait_ff;
  logic rx_ovf_ff, tx_unf_ff;
  logic rx_hold_valid_ff;
  logic [15:0] rx_hold_ff;
  logic en, slave, long_mode, fs16k, mclk_en;
  logic [1:0] rate;
  logic [2:0] frame_sel;
  assign en = ctrl_ff[CTRL_EN_BIT];
  assign slave = ctrl_ff[CTRL_SLAVE_BIT];
  assign long_mode = ctrl_ff[CTRL_LONG_BIT];
  assign fs16k = ctrl_ff[CTRL_FS16K_BIT];
  assign rate = ctrl_ff[CTRL_RATE_LSB +: 2];
  assign frame_sel = ctrl_ff[CTRL_FRAME_LSB +: 3];
  assign mclk_en = ctrl_ff[CTRL_MCLK_EN_BIT];

  // Transmit FIFO between register writes and the shifter
  logic tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
  logic [15:0] tx_out_data;
  voice_fifo #(.WIDTH(SAMPLE_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_data_in(avs_writedata_in[15:0]),
    .in_valid_in(tx_in_valid),
    .in_ready_out(tx_in_ready),
    .out_data_out(tx_out_data),
    .out_valid_out(tx_out_valid),
    .out_ready_in(tx_out_ready)
  );

  // Bus slave; a full FIFO stalls the write through waitrequest
  logic bus_req, acc_ok, is_tx_wr, is_rx_rd;
  assign bus_req = (avs_read_in || avs_write_in) && bus_ff == BUS_IDLE;
  assign is_tx_wr = avs_write_in && avs_address_in == ADDR_TXDATA;
  assign is_rx_rd = avs_read_in && avs_address_in == ADDR_RXDATA;
  assign acc_ok = bus_req && (!is_tx_wr || tx_in_ready);
  assign tx_in_valid = acc_ok && is_tx_wr;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_ff <= BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      unique case (bus_ff)
        BUS_IDLE: begin
          if (acc_ok) begin
            bus_ff <= BUS_ACK;
            wait_ff <= 1'b0;
            unique case (avs_address_in)
              ADDR_CTRL: rdata_ff <= {16'h0000, ctrl_ff};
              ADDR_STATUS: rdata_ff <= {27'h000_0000, rx_hold_valid_ff, rx_ovf_ff,
                tx_unf_ff, tx_in_ready, tx_out_valid};
              ADDR_RXDATA: rdata_ff <= {16'h0000, rx_hold_ff};
              default: rdata_ff <= 32'h0000_0000;
            endcase
          end
        end
        BUS_ACK: begin
          bus_ff <= BUS_DONE;
          wait_ff <= 1'b1;
        end
        default: bus_ff <= BUS_IDLE;
      endcase
    end
  end
  assign avs_readdata_out = rdata_ff;
  assign avs_waitrequest_out = wait_ff;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_ff <= CTRL_RESET;
    end else if (acc_ok && avs_write_in && avs_address_in == ADDR_CTRL) begin
      if (avs_byteenable_in[0]) begin
        ctrl_ff[7:0] <= avs_writedata_in[7:0];
      end
      if (avs_byteenable_in[1]) begin
        ctrl_ff[15:8] <= avs_writedata_in[15:8];
      end
    end
  end

  // Pin synchronisers
  logic [1:0] bclk_sy_ff, fs_sy_ff, din_sy_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bclk_sy_ff <= 2'b00;
      fs_sy_ff <= 2'b00;
      din_sy_ff <= 2'b00;
    end else begin
      bclk_sy_ff <= {bclk_sy_ff[0], voice_bclk_in};
      fs_sy_ff <= {fs_sy_ff[0], voice_frame_sync_in};
      din_sy_ff <= {din_sy_ff[0], voice_din_in};
    end
  end

  // Master bit clock and frame sync generation
  logic [11:0] half_cnt_ff;
  logic [15:0] frame_cnt_ff;
  logic bclk_ff, fs_pend_ff, fs_ff;
  logic m_rise, m_fall, frame_tick;
  assign m_rise = en && !slave && half_cnt_ff == 12'h000 && !bclk_ff;
  assign m_fall = en && !slave && half_cnt_ff == 12'h000 && bclk_ff;
  assign frame_tick = en && !slave && frame_cnt_ff == 16'h0000;
  always_ff @(posedge clk_in) begin
    if (rst_in || !en || slave) begin
      half_cnt_ff <= 12'h000;
      bclk_ff <= 1'b0;
    end else if (half_cnt_ff == 12'h000) begin
      half_cnt_ff <= half_period(rate, long_mode) - 12'h001;
      bclk_ff <= !bclk_ff;
    end else begin
      half_cnt_ff <= half_cnt_ff - 12'h001;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || !en || slave) begin
      frame_cnt_ff <= 16'h0000;
    end else if (frame_cnt_ff == 16'h0000) begin
      frame_cnt_ff <= 16'(fs16k ? FRAME_16K_CYC - 1 : FRAME_8K_CYC - 1);
    end else begin
      frame_cnt_ff <= frame_cnt_ff - 16'h0001;
    end
  end
  // Sync raised on a rising edge, half a period after the prior falling edge
  logic [8:0] bit_cnt_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in || !en || slave) begin
      fs_pend_ff <= 1'b0;
      fs_ff <= 1'b0;
    end else begin
      if (frame_tick) begin
        fs_pend_ff <= 1'b1;
      end else if (m_rise && fs_pend_ff) begin
        fs_pend_ff <= 1'b0;
      end
      if (m_rise && fs_pend_ff) begin
        fs_ff <= 1'b1;
      end else if (m_rise && (!long_mode || bit_cnt_ff == 9'(SAMPLE_BITS))) begin
        fs_ff <= 1'b0; // short: one period; long: 17 periods, one past the 16-bit slot
      end
    end
  end

  // Common bit-clock edges for master and slave
  logic rise_ev, fall_ev, fs_now, bclk_prev_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bclk_prev_ff <= 1'b0;
    end else begin
      bclk_prev_ff <= bclk_sy_ff[1];
    end
  end
  assign rise_ev = slave ? (en && bclk_sy_ff[1] && !bclk_prev_ff) : m_rise;
  assign fall_ev = slave ? (en && !bclk_sy_ff[1] && bclk_prev_ff) : m_fall;
  assign fs_now = slave ? fs_sy_ff[1] : (fs_ff || (m_rise && fs_pend_ff));

  // Slot shifter; frame length bounds only the receive window, not the bit counter
  // Counter runs on past the slot and saturates at all ones; only counts below 16 shift a bit
  logic [8:0] frame_len;
  assign frame_len = 9'h008 << frame_sel;
  logic [15:0] tx_sh_ff, rx_sh_ff;
  logic dout_ff, dout_oe_ff, fs_seen_ff, in_slot;
  assign in_slot = bit_cnt_ff < 9'(SAMPLE_BITS) && bit_cnt_ff < frame_len;
  assign tx_out_ready = rise_ev && fs_now && !fs_seen_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in || !en) begin
      bit_cnt_ff <= 9'h1ff;
      tx_sh_ff <= 16'h0000;
      dout_ff <= 1'b0;
      dout_oe_ff <= 1'b0;
      fs_seen_ff <= 1'b0;
    end else if (rise_ev) begin
      fs_seen_ff <= fs_now;
      if (fs_now && !fs_seen_ff) begin
        bit_cnt_ff <= 9'h000;
        tx_sh_ff <= {tx_out_data[14:0], 1'b0};
        dout_ff <= tx_out_valid ? tx_out_data[15] : 1'b0;
        dout_oe_ff <= 1'b1;
      end else if (bit_cnt_ff < 9'h1ff) begin
        bit_cnt_ff <= bit_cnt_ff + 9'h001;
        if (bit_cnt_ff + 9'h001 < 9'(SAMPLE_BITS)) begin
          dout_ff <= tx_sh_ff[15];
          tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
        end
      end
    end else if (fall_ev && bit_cnt_ff == 9'(SAMPLE_BITS - 1)) begin
      dout_oe_ff <= 1'b0;
    end
  end

  // Underrun flag in its own process so that a clear is never lost to a
  // bit-clock edge; a new underrun still outweighs a clear in the same cycle
  logic unf_clr, ovf_clr;
  assign unf_clr = acc_ok && avs_write_in && avs_address_in == ADDR_STATUS
    && avs_writedata_in[2];
  assign ovf_clr = acc_ok && avs_write_in && avs_address_in == ADDR_STATUS
    && avs_writedata_in[3];
  always_ff @(posedge clk_in) begin
    if (rst_in || !en) begin
      tx_unf_ff <= 1'b0;
    end else if (tx_out_ready && !tx_out_valid) begin
      tx_unf_ff <= 1'b1;
    end else if (unf_clr) begin
      tx_unf_ff <= 1'b0;
    end
  end

  // Receive: falling edges in both sync formats
  always_ff @(posedge clk_in) begin
    if (rst_in || !en) begin
      rx_sh_ff <= 16'h0000;
      rx_hold_ff <= 16'h0000;
      rx_hold_valid_ff <= 1'b0;
      rx_ovf_ff <= 1'b0;
    end else begin
      if (fall_ev && in_slot) begin
        rx_sh_ff <= {rx_sh_ff[14:0], din_sy_ff[1]};
      end
      if (fall_ev && bit_cnt_ff == 9'(SAMPLE_BITS - 1)) begin
        rx_hold_ff <= {rx_sh_ff[14:0], din_sy_ff[1]};
        rx_hold_valid_ff <= 1'b1;
      end else if (acc_ok && is_rx_rd) begin
        rx_hold_valid_ff <= 1'b0;
      end
      // Set wins over clear; a clear with no new overrun still applies
      if (fall_ev && bit_cnt_ff == 9'(SAMPLE_BITS - 1) && rx_hold_valid_ff) begin
        rx_ovf_ff <= 1'b1;
      end else if (ovf_clr) begin
        rx_ovf_ff <= 1'b0;
      end
    end
  end

  // Codec master clock from a phase accumulator
  // Edges jitter by one system cycle; a codec needing a clean clock
  // must clean it with its own PLL
  logic [31:0] mclk_acc_ff;
  logic mclk_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in || !mclk_en) begin
      mclk_acc_ff <= 32'h0000_0000;
      mclk_ff <= 1'b0;
    end else begin
      mclk_acc_ff <= mclk_acc_ff + MCLK_INC;
      mclk_ff <= mclk_acc_ff[31];
    end
  end

  // Registered pin outputs
  // All pins lag internal state by one cycle, keeping their mutual timing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      voice_bclk_out <= 1'b0;
      voice_bclk_oe_out <= 1'b0;
      voice_frame_sync_out <= 1'b0;
      voice_frame_sync_oe_out <= 1'b0;
      voice_dout_out <= 1'b0;
      voice_dout_oe_out <= 1'b0;
      codec_mclk_out <= 1'b0;
    end else begin
      voice_bclk_out <= bclk_ff;
      voice_bclk_oe_out <= en && !slave;
      voice_frame_sync_out <= fs_ff;
      voice_frame_sync_oe_out <= en && !slave;
      voice_dout_out <= dout_ff;
      voice_dout_oe_out <= dout_oe_ff;
      codec_mclk_out <= mclk_ff;
    end
  end
endmodule
`default_nettype wire

/* rtl/voice_fifo.sv */
// Small valid/ready FIFO for voice samples
`timescale 1ns/1ns
`default_nettype none
module voice_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff;
  logic [AW:0] cnt_ff;
  logic push, pop;
  assign in_ready_out = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out = mem[rd_ff];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ff] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* rtl/voice_port_pkg.sv */
// Shared constants for the PCM voice port
package voice_port_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_TXDATA = 4'h8;
  localparam logic [3:0] ADDR_RXDATA = 4'hc;
  // Control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SLAVE_BIT = 1;
  localparam int CTRL_LONG_BIT = 2;
  localparam int CTRL_FS16K_BIT = 3;
  localparam int CTRL_RATE_LSB = 4;
  localparam int CTRL_FRAME_LSB = 8;
  localparam int CTRL_MCLK_EN_BIT = 12;
  // Control reset value: enabled=0, master, short, 8 kHz, 2048 kHz, 256 bits, mclk on
  localparam logic [15:0] CTRL_RESET = 16'h1530;
  localparam int SAMPLE_BITS = 16;
  // Bit clock rates
  localparam int unsigned BCLK_256K_HZ = 256_000;
  localparam int unsigned BCLK_512K_HZ = 512_000;
  localparam int unsigned BCLK_1024K_HZ = 1_024_000;
  localparam int unsigned BCLK_2048K_HZ = 2_048_000;
  localparam int unsigned BCLK_LONG_HZ = 128_000;
  localparam logic [1:0] RATE_256K = 2'h0;
  localparam logic [1:0] RATE_512K = 2'h1;
  localparam logic [1:0] RATE_1024K = 2'h2;
  localparam logic [1:0] RATE_2048K = 2'h3;
  // Half bit clock periods in system cycles (rounded down)
  localparam int HALF_256K = CLK_HZ / (2 * BCLK_256K_HZ);
  localparam int HALF_512K = CLK_HZ / (2 * BCLK_512K_HZ);
  localparam int HALF_1024K = CLK_HZ / (2 * BCLK_1024K_HZ);
  localparam int HALF_2048K = CLK_HZ / (2 * BCLK_2048K_HZ);
  localparam int HALF_LONG = CLK_HZ / (2 * BCLK_LONG_HZ);
  // Frame sync repeat period
  localparam int unsigned FRAME_8K_HZ = 8_000;
  localparam int unsigned FRAME_16K_HZ = 16_000;
  localparam int FRAME_8K_CYC = CLK_HZ / FRAME_8K_HZ;
  localparam int FRAME_16K_CYC = CLK_HZ / FRAME_16K_HZ;
  // Codec master clock 12.288 MHz = 256 x 48 kHz, by phase accumulator
  localparam int unsigned MCLK_FS_HZ = 48_000;
  localparam int unsigned MCLK_RATIO = 256;
  localparam int unsigned MCLK_HZ = MCLK_FS_HZ * MCLK_RATIO;
  localparam logic [31:0] MCLK_INC = 32'(
    (64'(MCLK_HZ) * 64'h1_0000_0000) / 64'(CLK_HZ));
endpackage

/* verif/codec_model.sv */
// Behavioural codec on the far side of the voice link
`timescale 1ns/1ns
`default_nettype none
module codec_model (
  input wire logic clk_in,
  input wire logic bclk_in,
  input wire logic sync_in,
  input wire logic dout_in,
  input wire logic dout_oe_in,
  input wire logic [15:0] word_in,
  output logic din_out,
  output logic [15:0] rx_word_out,
  output logic rx_done_out
);
  logic bclk_q = 1'b0;
  logic sync_q = 1'b0;
  logic [15:0] tx_sh = 16'h0000;
  logic [15:0] rx_sh = 16'h0000;
  logic [4:0] tx_cnt = 5'h10;
  logic [4:0] rx_cnt = 5'h00;
  logic oe_q = 1'b0;
  initial din_out = 1'b0;
  initial rx_word_out = 16'h0000;
  initial rx_done_out = 1'b0;
  always @(posedge clk_in) begin
    bclk_q <= bclk_in;
    oe_q <= dout_oe_in;
    rx_done_out <= 1'b0;
    if (bclk_in && !bclk_q) begin
      sync_q <= sync_in;
      if (sync_in && !sync_q) begin
        din_out <= word_in[15];
        tx_sh <= word_in << 1;
        tx_cnt <= 5'h01;
        rx_cnt <= 5'h00;
      end else if (tx_cnt < 5'h10) begin
        din_out <= tx_sh[15];
        tx_sh <= tx_sh << 1;
        tx_cnt <= tx_cnt + 5'h01;
      end else begin
        // Released line toggles so no stale bit can pass
        din_out <= ~din_out;
      end
    end
    // Last bit falls on the same edge that releases the line
    if (!bclk_in && bclk_q && (dout_oe_in || oe_q)) begin
      rx_sh <= {rx_sh[14:0], dout_in};
      rx_cnt <= rx_cnt == 5'h0f ? 5'h00 : rx_cnt + 5'h01;
      rx_done_out <= rx_cnt == 5'h0f;
      if (rx_cnt == 5'h0f) rx_word_out <= {rx_sh[14:0], dout_in};
    end
  end
endmodule
`default_nettype wire

/* verif/pcm_voice_port_bench.sv */
// Self-checking bench for the PCM voice port
`timescale 1ns/1ns
`default_nettype none
module pcm_voice_port_bench;
  import voice_port_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, voice_frame_sync_out, voice_frame_sync_oe_out;
  logic voice_bclk_out, voice_bclk_oe_out, voice_dout_out, voice_dout_oe_out, codec_mclk_out;
  wire logic voice_frame_sync_in;
  wire logic voice_bclk_in;
  wire logic voice_din_in;
  logic [15:0] codec_word = 16'h0000;
  logic [15:0] last_sent = 16'h0000;
  logic [15:0] rx_word;
  logic [15:0] tx_exp[$];
  logic [31:0] q;
  logic rx_done;
  logic mon_on = 1'b0;
  logic slave_on = 1'b0;
  logic ext_bclk = 1'b0;
  logic ext_sync = 1'b0;
  int bad_count = 0;
  int tests_run = 0;
  int frames = 0;
  int seed = 32'h0f0c_75cb;
  // Pull-downs hold undriven link pins low
  assign voice_frame_sync_in = slave_on ? ext_sync : voice_frame_sync_oe_out & voice_frame_sync_out;
  assign voice_bclk_in = slave_on ? ext_bclk : voice_bclk_oe_out & voice_bclk_out;
  initial forever #2 clk_in = ~clk_in;
  // Codec-side link clock for slave mode: 125 ns, sync one bit per 32-bit frame
  initial begin
    int n;
    n = 0;
    forever begin
      #62;
      ext_bclk = 1'b1;
      #63;
      ext_bclk = 1'b0;
      n = (n + 1) % 32;
      ext_sync = slave_on && n == 0;
    end
  end
  pcm_voice_port #(.FIFO_DEPTH(8)) u_dut (.*);
  codec_model u_codec (
    .clk_in(clk_in),
    .bclk_in(voice_bclk_in),
    .sync_in(voice_frame_sync_in),
    .dout_in(voice_dout_out),
    .dout_oe_in(voice_dout_oe_out),
    .word_in(codec_word),
    .din_out(voice_din_in),
    .rx_word_out(rx_word),
    .rx_done_out(rx_done)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = frames + n;
    while (frames < t) @(posedge clk_in);
  endtask
  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    if (rx_done) begin
      if (mon_on) check(rx_word, tx_exp.size() > 0 ? tx_exp.pop_front() : 16'h0000);
      last_sent <= codec_word;
      codec_word <= 16'($random(seed));
      frames <= frames + 1;
    end
  end
  initial begin
    repeat (80000) @(posedge clk_in);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    bus(1'b0, ADDR_CTRL, 32'h0000_0000);
    check(q, {16'h0000, CTRL_RESET});
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(q, 32'h0000_0002);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0000_0000);
    check(q, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, ADDR_CTRL, 32'h0000_1000 | i << 8 | (i % 4) << 4);
      bus(1'b0, ADDR_CTRL, 32'h0000_0000);
      check(q, 32'h0000_1000 | i << 8 | (i % 4) << 4);
    end
    // Fill the buffer while the link is idle
    for (int i = 0; i < 8; i++) begin
      q = $random(seed);
      tx_exp.push_back(q[15:0]);
      bus(1'b1, ADDR_TXDATA, q);
    end
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(q, 32'h0000_0001);
    mon_on <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h0000_1539);
    wait_frames(3);
    repeat (50) @(posedge clk_in);
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(q, 32'h0000_001b);
    bus(1'b1, ADDR_STATUS, 32'h0000_0008);
    bus(1'b0, ADDR_RXDATA, 32'h0000_0000);
    check(q, {16'h0000, last_sent});
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(q, 32'h0000_0003);
    // Rate changes can split a slot, so words are no longer compared
    mon_on <= 1'b0;
    for (int r = 0; r < 5; r++) begin
      bus(1'b1, ADDR_CTRL, 32'h0000_1509 | (r == 4 ? 32'h0000_0004 : r << 4));
      repeat (4 * HALF_LONG + 40) @(posedge clk_in);
    end
    // Slave: codec supplies bit clock and sync, 32-bit frames
    slave_on <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h0000_1203);
    wait_frames(2);
    repeat (20) @(posedge clk_in);
    bus(1'b0, ADDR_RXDATA, 32'h0000_0000);
    check(q, {16'h0000, last_sent});
    conclude();
  end
endmodule
`default_nettype wire

/* verif/voice_port_assertions.sv */
// Port-level assertions for the PCM voice port
`timescale 1ns/1ns
`default_nettype none
module voice_port_checker
  import voice_port_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  input wire logic voice_frame_sync_out,
  input wire logic voice_frame_sync_oe_out,
  input wire logic voice_bclk_out,
  input wire logic voice_bclk_oe_out,
  input wire logic voice_dout_oe_out,
  input wire logic voice_dout_out,
  input wire logic codec_mclk_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [15:0] ctrl_ff;
  logic [15:0] bclk_run_ff, sync_run_ff, frame_run_ff;
  logic [4:0] mclk_run_ff, bits_ff;
  logic [1:0] steady_ff;
  logic frame_ok_ff, mclk_ok_ff, bclk_q_ff, sync_q_ff, mclk_q_ff;
  int half;
  int frame;
  // Shadow assumes whole-word control writes
  wire logic ctrl_req = avs_write_in && avs_address_in == ADDR_CTRL;
  wire logic mst = ctrl_ff[0] && !ctrl_ff[1];
  wire logic b_edge = voice_bclk_out != bclk_q_ff;
  wire logic s_edge = voice_frame_sync_out != sync_q_ff;
  wire logic m_edge = codec_mclk_out != mclk_q_ff;
  assign half = ctrl_ff[2] ? HALF_LONG : ctrl_ff[5:4] == RATE_256K ? HALF_256K :
    ctrl_ff[5:4] == RATE_512K ? HALF_512K : ctrl_ff[5:4] == RATE_1024K ? HALF_1024K : HALF_2048K;
  assign frame = ctrl_ff[3] ? FRAME_16K_CYC : FRAME_8K_CYC;
  always_ff @(posedge clk_in) begin
    if (rst_in) ctrl_ff <= CTRL_RESET;
    else if (ctrl_req && !avs_waitrequest_out) ctrl_ff <= avs_writedata_in[15:0];
  end
  always_ff @(posedge clk_in) begin
    bclk_q_ff <= voice_bclk_out;
    sync_q_ff <= voice_frame_sync_out;
    mclk_q_ff <= codec_mclk_out;
    bclk_run_ff <= b_edge ? 16'h0001 : bclk_run_ff + 16'h0001;
    sync_run_ff <= s_edge ? 16'h0001 : sync_run_ff + 16'h0001;
    frame_run_ff <= s_edge && voice_frame_sync_out ? 16'h0001 : frame_run_ff + 16'h0001;
    mclk_run_ff <= m_edge ? 5'h01 : mclk_run_ff + 5'h01;
  end
  // Runs measured across a mode change are meaningless, so restart
  always_ff @(posedge clk_in) begin
    if (rst_in || ctrl_req) begin
      steady_ff <= 2'h0;
      frame_ok_ff <= 1'b0;
      mclk_ok_ff <= 1'b0;
    end else begin
      if (b_edge && steady_ff != 2'h3) steady_ff <= steady_ff + 2'h1;
      if (s_edge && voice_frame_sync_out) frame_ok_ff <= 1'b1;
      if (m_edge) mclk_ok_ff <= 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!voice_dout_oe_out) bits_ff <= 5'h00;
    else if (b_edge && !voice_bclk_out) bits_ff <= bits_ff + 5'h01;
  end
  a_bclk_half: assert property (mst && steady_ff == 2'h3 && b_edge |-> bclk_run_ff == half)
    else $error("bit clock half period wrong");
  a_sync_width: assert property (mst && !ctrl_ff[2] && steady_ff == 2'h3 && s_edge
    && !voice_frame_sync_out |-> sync_run_ff == 2 * half)
    else $error("short sync width wrong");
  a_sync_place: assert property (mst && $rose(voice_frame_sync_out) |-> $rose(voice_bclk_out))
    else $error("sync not on bit clock rise");
  a_frame_rate: assert property (mst && frame_ok_ff && s_edge && voice_frame_sync_out
    |-> frame_run_ff inside {[frame - 2 * half : frame + 2 * half]})
    else $error("frame period wrong");
  a_dout_change: assert property (mst && voice_dout_oe_out && $past(voice_dout_oe_out)
    && $changed(voice_dout_out) |-> $rose(voice_bclk_out))
    else $error("serial out changed off a rising edge");
  a_dout_release: assert property (mst && $fell(voice_dout_oe_out) |-> $fell(voice_bclk_out))
    else $error("serial out released off a falling edge");
  a_slot_bits: assert property (mst && $fell(voice_dout_oe_out) |-> bits_ff == 5'h0f)
    else $error("slot not sixteen bits");
  a_slot_start: assert property (mst && $rose(voice_dout_oe_out)
    |-> $rose(voice_frame_sync_out))
    else $error("slot not at sync");
  a_pins_driven: assert property (mst && steady_ff == 2'h3
    |-> voice_bclk_oe_out && voice_frame_sync_oe_out)
    else $error("master pins not driven");
  a_mclk_rate: assert property (ctrl_ff[12] && mclk_ok_ff && m_edge
    |-> mclk_run_ff inside {[5'h0a : 5'h0b]})
    else $error("master clock rate wrong");
endmodule
bind pcm_voice_port voice_port_checker u_chk (.*);
`default_nettype wire
